// ===== hdl/sio_check_defs.vh
// Field positions, codes and register map for the start I/O checker
`ifndef SIO_CHECK_DEFS_VH
`define SIO_CHECK_DEFS_VH
// Address word: 32-bit word, bit 0 is the most significant
`define AW_KEY_HI 31
`define AW_MODE_HI 27
`define AW_MODE_LO 24
`define AW_ENABLE 26
// Command word: 64-bit word, bit 0 is the most significant
`define CW_OP_HI 63
`define CW_OP_LO 56
`define CW_XL_HI 25
`define CW_XL_LO 24
`define CW_OP_TIC 4'h8
// Mode codes of address word bits 4-7
`define MODE_TAPE_MOVE 4'h4
`define MODE_DISK_MOVE 4'h5
`define MODE_TAPE_LOAD 4'h6
`define MODE_DISK_LOAD 4'h7
`define MODE_TAPE_MOVE_ODD 4'hC
`define MODE_BAD_D 4'hD
`define MODE_TAPE_LOAD_ODD 4'hE
`define MODE_BAD_F 4'hF
// Translator codes of command word bits 38-39
`define XL_NONE 2'b00
`define XL_UNDEF 2'b01
`define XL_LOAD 2'b10
`define XL_MOVE 2'b11
// Channel and unit address width
`define UNIT_W 11
// Register offsets
`define REG_STATUS 4'h0
`define REG_IRQ 4'h4
`define REG_MASK 4'h8
`define REG_UNIT 4'hC
// Status word bit positions
`define ST_PCHK 0
`define ST_DONE 1
`define IRQ_W 2
`endif

// ===== hdl/addr_word_check.v
// Address word check and mode decode
`timescale 1ns/100ps
module addr_word_check (
   // Inputs
   input wire [31:0] i_word,
   input wire i_diag,
   // Results
   output reg o_bad,
   output reg [3:0] o_mode,
   output reg o_illegal
);
`include "sio_check_defs.vh"
   always @* begin
      o_mode = i_word[`AW_MODE_HI:`AW_MODE_LO];
      o_illegal = 1'b0;
      o_bad = 1'b0;
      if (!i_diag) begin
         o_bad = (o_mode != 4'h0);
      end else begin
         o_bad = !i_word[`AW_ENABLE];
         case (o_mode)
            `MODE_BAD_D, `MODE_BAD_F: o_illegal = 1'b1;
            default: o_illegal = 1'b0;
         endcase
      end
   end
endmodule

// ===== hdl/cmd_word_check.v
// Command word reserved-bit check and translator decode
`timescale 1ns/100ps
module cmd_word_check (
   // Inputs
   input wire [63:0] i_word,
   input wire i_diag,
   input wire i_write_op,
   // Results
   output reg o_bad,
   output reg [2:0] o_xl
);
`include "sio_check_defs.vh"
   // o_xl: 0 none, 1 undefined, 2 load read, 3 move read, 4 write xlate
   reg [1:0] code;
   reg tic;
   always @* begin
      code = i_word[`CW_XL_HI:`CW_XL_LO];
      tic = (i_word[59:56] == `CW_OP_TIC);
      o_bad = 1'b0;
      o_xl = 3'd0;
      if (!i_diag) begin
         o_bad = !tic && (code != 2'b00);
      end else begin
         case (code)
            `XL_NONE: o_xl = 3'd0;
            `XL_UNDEF: o_xl = 3'd1;
            `XL_LOAD: o_xl = 3'd2;
            `XL_MOVE: o_xl = i_write_op ? 3'd4 : 3'd3;
            default: o_xl = 3'd0;
         endcase
      end
   end
endmodule

// ===== hdl/start_io_diagnose_check.v
// Start I/O and diagnose-form word checker with register port
// Overview of operation
// - Ordinary start I/O needs address word bits 4-7 zero, else program check.
// - Ordinary start I/O needs command word bits 38-39 zero unless TIC.
// - The diagnose form skips those checks and reads the bits as controls.
// - The diagnose form needs address word bit 5 set, else program check.
// - Modes 0100, 0101, 1100 are tape move, disk move, odd tape move.
// - Modes 0110, 0111, 1110 are tape load, disk load, odd tape load.
// - Command bits 00 no translation, 01 undefined, 10 load on read.
// - Command bits 11 give move with wordmarks on read, write xlate on write.
// - Channel and unit address is the low eleven bits of the named register.
//
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/100ps
module start_io_diagnose_check (
   // Clock and reset
   input wire i_clk,
   input wire i_nrst,
   // Operation request
   input wire i_start,
   input wire i_diag,
   input wire [31:0] i_channel_address_word,
   input wire [31:0] i_general_register_operand,
   // Command word stream
   input wire i_cw_valid,
   input wire i_cw_write_op,
   input wire [63:0] i_channel_command_word,
   // Register port
   input wire [3:0] i_addr,
   input wire [31:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   output reg [31:0] o_rdata,
   // Decoded results
   output reg o_program_check,
   output reg o_move_mode,
   output reg o_load_mode,
   output reg o_disk,
   output reg o_odd_parity,
   output reg [2:0] o_xlate,
   output reg [10:0] o_unit_addr,
   output reg o_irq
);
`include "sio_check_defs.vh"
   ////////////////////////////////////////////////////////////////////////
   wire aw_bad;
   wire aw_ill;
   wire [3:0] aw_mode;
   wire cw_bad;
   wire [2:0] cw_xl;
   reg diag_r;
   reg active_r;
   reg [31:0] csw_r;
   reg [`IRQ_W-1:0] irq_r;
   reg [`IRQ_W-1:0] mask_r;
   reg [`IRQ_W-1:0] ev;
   reg [`IRQ_W-1:0] irq_nxt;
   addr_word_check u_aw (
      .i_word(i_channel_address_word),
      .i_diag(i_diag),
      .o_bad(aw_bad),
      .o_mode(aw_mode),
      .o_illegal(aw_ill)
   );
   cmd_word_check u_cw (
      .i_word(i_channel_command_word),
      .i_diag(diag_r),
      .i_write_op(i_cw_write_op),
      .o_bad(cw_bad),
      .o_xl(cw_xl)
   );
   ////////////////////////////////////////////////////////////////////////
   wire aw_fail = i_start && (aw_bad || aw_ill);
   wire cw_fail = i_cw_valid && active_r && cw_bad;
   always @* begin
      ev = {`IRQ_W{1'b0}};
      ev[`ST_PCHK] = aw_fail || cw_fail;
      ev[`ST_DONE] = i_start;
      // Set wins over a write-one clear in the same cycle
      irq_nxt = irq_r;
      if (i_wr && i_addr == `REG_IRQ) begin
         irq_nxt = irq_r & ~i_wdata[`IRQ_W-1:0];
      end
      irq_nxt = irq_nxt | ev;
   end
   always @(posedge i_clk) begin
      if (!i_nrst) begin
         diag_r <= 1'b0;
         active_r <= 1'b0;
         csw_r <= 32'h0000_0000;
         irq_r <= {`IRQ_W{1'b0}};
         mask_r <= {`IRQ_W{1'b0}};
         o_rdata <= 32'h0000_0000;
         o_program_check <= 1'b0;
         o_move_mode <= 1'b0;
         o_load_mode <= 1'b0;
         o_disk <= 1'b0;
         o_odd_parity <= 1'b0;
         o_xlate <= 3'd0;
         o_unit_addr <= 11'd0;
         o_irq <= 1'b0;
      end else begin
         irq_r <= irq_nxt;
         o_irq <= |(irq_nxt & mask_r);
         if (i_wr && i_addr == `REG_MASK) begin
            mask_r <= i_wdata[`IRQ_W-1:0];
         end
         if (i_start) begin
            diag_r <= i_diag;
            active_r <= !aw_fail;
            o_program_check <= aw_fail;
            csw_r[`ST_PCHK] <= aw_fail;
            o_unit_addr <= i_general_register_operand[`UNIT_W-1:0];
            o_move_mode <= 1'b0;
            o_load_mode <= 1'b0;
            o_disk <= 1'b0;
            o_odd_parity <= 1'b0;
            o_xlate <= 3'd0;
            if (i_diag && !aw_fail) begin
               case (aw_mode)
                  `MODE_TAPE_MOVE: o_move_mode <= 1'b1;
                  `MODE_DISK_MOVE: begin
                     o_move_mode <= 1'b1;
                     o_disk <= 1'b1;
                  end
                  `MODE_TAPE_MOVE_ODD: begin
                     o_move_mode <= 1'b1;
                     o_odd_parity <= 1'b1;
                  end
                  `MODE_TAPE_LOAD: o_load_mode <= 1'b1;
                  `MODE_DISK_LOAD: begin
                     o_load_mode <= 1'b1;
                     o_disk <= 1'b1;
                  end
                  `MODE_TAPE_LOAD_ODD: begin
                     o_load_mode <= 1'b1;
                     o_odd_parity <= 1'b1;
                  end
                  default: o_move_mode <= 1'b0;
               endcase
            end
         end else if (i_cw_valid && active_r) begin
            if (cw_fail) begin
               // Chain stops at the first bad word
               active_r <= 1'b0;
               o_program_check <= 1'b1;
               csw_r[`ST_PCHK] <= 1'b1;
            end else begin
               o_xlate <= cw_xl;
            end
         end
         o_rdata <= 32'h0000_0000;
         if (i_rd) begin
            case (i_addr)
               `REG_STATUS: o_rdata <= csw_r;
               `REG_IRQ: o_rdata <= {{(32-`IRQ_W){1'b0}}, irq_r};
               `REG_MASK: o_rdata <= {{(32-`IRQ_W){1'b0}}, mask_r};
               `REG_UNIT: o_rdata <= {21'd0, o_unit_addr};
               default: o_rdata <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule

// ===== dv/sio_check_assertions.sv
// Port checks for the start I/O checker
`timescale 1ns/100ps
module sio_check_assertions (
   // Watched ports
   input wire i_clk,
   input wire i_nrst,
   input wire i_start,
   input wire i_diag,
   input wire [31:0] i_channel_address_word,
   input wire [31:0] i_general_register_operand,
   input wire i_cw_valid,
   input wire i_cw_write_op,
   input wire [63:0] i_channel_command_word,
   input wire o_program_check,
   input wire o_move_mode,
   input wire o_load_mode,
   input wire o_disk,
   input wire o_odd_parity,
   input wire [2:0] o_xlate,
   input wire [10:0] o_unit_addr
);
   wire [3:0] m = i_channel_address_word[27:24];
   wire [3:0] md = {o_move_mode, o_load_mode, o_disk, o_odd_parity};
   wire ds = i_start && i_diag;
   // Bit 5 set and not one of the two rejected codes
   wire ok = m[2] && !(m[3] && m[0]);
   wire cw = i_cw_valid && !i_start;
   reg [3:0] pm, pk;
   reg [10:0] pu;
   always @(posedge i_clk) begin
      pm <= m;
      pk <= {i_cw_write_op, i_channel_command_word[59:56] == 4'h8,
         i_channel_command_word[25:24]};
      pu <= i_general_register_operand[10:0];
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   sequence s_diag_go;
      ds && ok ##1 cw;
   endsequence
   sequence s_plain_go;
      i_start && !i_diag && m == 4'h0 ##1 cw;
   endsequence
   ////////////////////////////////////////
   a_plain_addr: assert property (i_start && !i_diag |=>
      o_program_check == (pm != 4'h0)) else $error("plain check");
   a_diag_bit5: assert property (ds && !m[2] |=> o_program_check)
      else $error("bit 5 check");
   a_bad_mode: assert property (ds && m[2] && m[3] && m[0] |=>
      o_program_check && !o_move_mode && !o_load_mode) else $error("bad mode");
   a_move_decode: assert property (ds && ok && !m[1] |=>
      md == {2'b10, pm[0], pm[3]}) else $error("move decode");
   a_load_decode: assert property (ds && ok && m[1] |=>
      md == {2'b01, pm[0], pm[3]} && !o_program_check) else $error("load");
   a_unit_addr: assert property (ds |=> o_unit_addr == pu)
      else $error("unit address");
   a_diag_skip: assert property (s_diag_go |=> !o_program_check)
      else $error("diag skip");
   a_xlate_code: assert property (s_diag_go |=> o_xlate ==
      (pk[1:0] == 2'b11 ? 3'd3 + pk[3] : {1'b0, pk[1:0]})) else $error("xl");
   a_cw_reserved: assert property (s_plain_go |=>
      o_program_check == (pk[1:0] != 2'b00 && !pk[2])) else $error("cw");
endmodule

// ===== dv/tb_top.sv
// Self-checking bench for the start I/O checker
`timescale 1ns/100ps
module tb_top;
   reg i_clk = 0, i_nrst = 0, i_start = 0, i_diag = 0, i_wr = 0, i_rd = 0;
   reg i_cw_valid = 0, i_cw_write_op = 0, d, wr;
   reg [3:0] i_addr = 0, m, op;
   reg [1:0] c;
   reg [31:0] i_wdata = 0, i_channel_address_word = 0;
   reg [31:0] i_general_register_operand = 0;
   reg [63:0] i_channel_command_word = 0;
   wire [31:0] o_rdata;
   wire o_program_check, o_move_mode, o_load_mode, o_disk, o_odd_parity, o_irq;
   wire [2:0] o_xlate;
   wire [10:0] o_unit_addr;
   wire [3:0] modes = {o_move_mode, o_load_mode, o_disk, o_odd_parity};
   integer miscompares = 0, num_checks = 0, i, epc, em;
   start_io_diagnose_check dut_u (.*);
   always #25 i_clk = ~i_clk;
   ////////////////////////////////////////
   task chk(input string n, input [31:0] e, s);
      num_checks = num_checks + 1;
      if (e !== s) begin
         miscompares = miscompares + 1;
         $display("unexpected %s: expected %h, seen %h", n, e, s);
      end
   endtask
   task give_verdict;
      if (miscompares == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task step(input s, v);
      @(posedge i_clk);
      i_start <= s;
      i_cw_valid <= v;
   endtask
   task bus(input w, input [3:0] a, input [31:0] v, k);
      @(posedge i_clk);
      i_wr <= w;
      i_rd <= !w;
      i_addr <= a;
      i_wdata <= v;
      @(posedge i_clk);
      i_wr <= 0;
      i_rd <= 0;
      #1 if (!w) chk("rdata", v, o_rdata & k);
   endtask
   ////////////////////////////////////////
   initial begin
      i = $urandom(32'h73f0);
      repeat (6) @(posedge i_clk);
      i_nrst <= 1;
      #1 chk("reset", 0, {o_irq, o_program_check, o_xlate});
      // Failing diagnose start, first seen with the interrupt masked
      step(1, 0);
      i_diag <= 1;
      i_general_register_operand <= 32'hffff_f5bc;
      step(0, 0);
      repeat (3) @(posedge i_clk);
      #1 chk("irq", 0, o_irq);
      bus(1, 4'h8, 1, 0);
      #50 chk("irq", 1, o_irq);
      bus(0, 4'h0, 1, 1);
      bus(0, 4'h4, 1, 1);
      bus(0, 4'hC, 32'h0000_05bc, 32'h0000_07ff);
      bus(0, 4'h2, 0, 32'hffff_ffff);
      bus(1, 4'h4, 1, 0);
      #50 chk("irq", 0, o_irq);
      for (i = 0; i < 300; i = i + 1) begin
         {d, wr, m, c} = $urandom;
         op = $urandom % 2 ? 4'h8 : $urandom;
         step(1, 0);
         i_diag <= d;
         i_channel_address_word <= $urandom & 32'hf0ff_ffff | m << 24;
         i_general_register_operand <= $urandom;
         step(0, 1);
         i_cw_write_op <= wr;
         i_channel_command_word <= {$urandom, $urandom} &
            64'hf0ff_ffff_fcff_ffff | op << 56 | c << 24;
         epc = d ? !m[2] || m[3] && m[0] : m != 0;
         em = epc || !d ? 0 : {!m[1], m[1], m[0], m[3]};
         #1 chk("pcheck", epc, o_program_check);
         chk("modes", em, modes);
         if (d) chk("unit", i_general_register_operand[10:0], o_unit_addr);
         step(0, 0);
         #1 if (!epc) begin
            chk("pcheck", !d && c != 0 && op != 8, o_program_check);
            if (d) chk("xlate", c == 3 ? 3 + wr : c, o_xlate);
         end
      end
      // Reset again in mid-run: results and the mask must be cleared
      @(posedge i_clk);
      i_nrst <= 0;
      repeat (3) @(posedge i_clk);
      i_nrst <= 1;
      #1 chk("reset2", 0, {o_irq, o_program_check, o_xlate, o_unit_addr});
      bus(0, 4'h8, 0, 32'hffff_ffff);
      give_verdict;
   end
   initial begin
      #200000;
      miscompares = miscompares + 1;
      give_verdict;
   end
endmodule
bind start_io_diagnose_check sio_check_assertions chk_u (.*);
